// >>> core/icgc_ctrl.sv
// control registers of the internal clock generator and their effects
// assumes a plain register port on clk and loop status from the analog side
//
// Summary of operation
// - bit 7 selects low power or high gain
// - write-once bits keep first value after reset
// - range bit picks prescale 64 or 1
// - range sets the prescale only in external modes
// - bit 5 picks external clock or crystal
// - mode field selects four clock modes
// - bypass waits for valid external reference
// - off mode leaves mode field unchanged
// - mode writes ignored while change completes
// - first write 0X blocks later 1X
// - bit 2 sets oscillator state in off
// - off setting void with high gain and range
// - bit 1 set disables clock loss detection
// - lock loss gives interrupt or reset request
// - loop factor is four plus twice code
// - multiplier writes ignored while change completes
// - clock loss gives interrupt or reset request
// - output divider is two to the code
// - divider writes ignored while change completes
// - reference valid only when stable and fast
// - lock lost flag sticky until cleared
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "icgc_params.svh"

module icgc_ctrl #(
  parameter int SETTLE_CYC = `ICGC_SETTLE_CYC,
  parameter int REF_GAP_CYC = `ICGC_REF_GAP_CYC,
  parameter int REF_EDGES = `ICGC_REF_EDGES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic external_reference_clock,
  input wire logic loop_locked,
  input wire logic clock_loss_event,
  input wire logic stop_request,
  input wire logic osc_enable_request,
  output logic osc_enable,
  output logic high_gain_select,
  output logic range_effective,
  output logic ext_reference_select,
  output icgc_pkg::icgc_mode_t active_mode,
  output icgc_pkg::icgc_loop_t loop_cfg,
  output logic out_clk_en,
  output icgc_pkg::icgc_req_t requests
);

  // count widths sized from the parameters
  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam int GW = $clog2(REF_GAP_CYC + 1);
  localparam int EW = $clog2(REF_EDGES + 1);

  function automatic logic busy_ok(input logic busy, input logic hit);
    busy_ok = hit & ~busy;
  endfunction

  // control register fields
  logic hgs;
  logic range_sel;
  logic ers;
  logic [1:0] mode_req;
  logic osc_keep_on_in_off;
  logic clock_loss_detect_off;
  logic lock_loss_action;
  logic [2:0] loop_multiplier_code;
  logic clock_loss_action;
  logic [2:0] output_divider_code;
  logic once_done;
  logic ext_blocked;

  // status and sequencing
  logic lock_lost_flag;
  logic clock_lost_flag;
  logic ext_reference_valid;
  logic reference_kind_status;
  icgc_pkg::icgc_mstate_t mstate;
  logic [SW-1:0] mode_cnt;
  logic [SW-1:0] mul_cnt;
  logic [SW-1:0] div_cnt;
  logic [2:0] mul_applied;
  logic [2:0] div_applied;
  logic [6:0] div_cnt_clk;

  // synchronisers
  logic [1:0] ref_sync;
  logic ref_prev;
  logic [1:0] lock_sync;
  logic lock_prev;
  logic [1:0] loss_sync;
  logic [GW-1:0] gap_cnt;
  logic [EW-1:0] edge_cnt;

  // bus decode
  wire wr_one = wr & (addr == `ICGC_ADDR_CTRL_ONE);
  wire wr_two = wr & (addr == `ICGC_ADDR_CTRL_TWO);
  wire wr_stat = wr & (addr == `ICGC_ADDR_STATUS);
  wire mode_busy = (mstate != icgc_pkg::ICGC_IDLE);
  wire mul_busy = (mul_cnt != '0);
  wire div_busy = (div_cnt != '0);
  wire [1:0] wr_mode = wdata[`ICGC_MODE_HI:`ICGC_MODE_LO];
  wire [2:0] wr_mul = wdata[`ICGC_MUL_HI:`ICGC_MUL_LO];
  wire [2:0] wr_div = wdata[`ICGC_DIV_HI:`ICGC_DIV_LO];
  wire mode_take = busy_ok(mode_busy, wr_one) & ~(ext_blocked & wr_mode[1]);
  wire mul_take = busy_ok(mul_busy, wr_two);
  wire div_take = busy_ok(div_busy, wr_two);
  wire in_off = stop_request;
  wire ext_mode_now = active_mode[1];
  wire engaged = (active_mode == icgc_pkg::ICGC_LOOP_INTERNAL) |
                 (active_mode == icgc_pkg::ICGC_LOOP_EXTERNAL);
  wire ref_edge = ref_sync[1] & ~ref_prev;
  wire lock_fall = lock_prev & ~lock_sync[1];
  wire lol_evt = lock_fall & engaged & ~mode_busy & ~in_off;
  wire loc_evt = loss_sync[1] & ~clock_loss_detect_off;
  wire clr_lol = wr_stat & wdata[`ICGC_ST_LOL_BIT];
  wire clr_loc = wr_stat & wdata[`ICGC_ST_LOC_BIT];

  wire off_keep = osc_keep_on_in_off ?
                  (mode_req[1] & reference_kind_status) :
                  (osc_enable_request & (mode_req == 2'h2) &
                   reference_kind_status);
  wire off_void = hgs & range_sel;
  wire run_osc = ext_mode_now | (mode_req[1] & ~ext_blocked);
  wire next_osc = in_off ? (off_void ? run_osc : off_keep) : run_osc;

  wire [7:0] ctrl_one_rd = {hgs, range_sel, ers, mode_req,
                            osc_keep_on_in_off, clock_loss_detect_off, 1'b0};
  wire [7:0] ctrl_two_rd = {lock_loss_action, loop_multiplier_code,
                            clock_loss_action, output_divider_code};
  wire [7:0] stat_rd = {active_mode, reference_kind_status, lock_lost_flag,
                        lock_sync[1] & engaged, clock_lost_flag,
                        ext_reference_valid, 1'b0};
  wire [7:0] next_rdata = (addr == `ICGC_ADDR_CTRL_ONE) ? ctrl_one_rd :
                          (addr == `ICGC_ADDR_CTRL_TWO) ? ctrl_two_rd :
                          (addr == `ICGC_ADDR_STATUS) ? stat_rd : 8'h00;

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hgs <= 1'b0;
      range_sel <= 1'b0;
      ers <= 1'b0;
      reference_kind_status <= 1'b0;
      once_done <= 1'b0;
      ext_blocked <= 1'b0;
    end else if (wr_one && !once_done) begin
      hgs <= wdata[`ICGC_HGS_BIT];
      range_sel <= wdata[`ICGC_RANGE_BIT];
      ers <= wdata[`ICGC_ERS_BIT];
      reference_kind_status <= wdata[`ICGC_ERS_BIT];
      once_done <= 1'b1;
      ext_blocked <= ~wr_mode[1];
    end
  end

  // freely writable control bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_keep_on_in_off <= 1'b0;
      clock_loss_detect_off <= 1'b0;
      lock_loss_action <= 1'b0;
      clock_loss_action <= 1'b0;
    end else begin
      if (wr_one) begin
        osc_keep_on_in_off <= wdata[`ICGC_OSC_OFF_BIT];
        clock_loss_detect_off <= wdata[`ICGC_CLOCK_LOSS_DETECT_OFF_BIT];
      end
      if (wr_two) begin
        lock_loss_action <= wdata[`ICGC_LLA_BIT];
        clock_loss_action <= wdata[`ICGC_CLA_BIT];
      end
    end
  end

  // mode change sequence
  // off mode freezes the sequence, so the request survives stop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_req <= 2'h0;
      active_mode <= icgc_pkg::ICGC_SELF_CLOCKED;
      mstate <= icgc_pkg::ICGC_IDLE;
      mode_cnt <= '0;
    end else begin
      case (mstate)
        icgc_pkg::ICGC_IDLE: begin
          if (mode_take) begin
            mode_req <= wr_mode;
            mode_cnt <= SW'(SETTLE_CYC);
            mstate <= icgc_pkg::ICGC_SETTLE;
          end
        end
        icgc_pkg::ICGC_SETTLE: begin
          if (!in_off) begin
            if (mode_cnt > SW'(1)) begin
              mode_cnt <= mode_cnt - SW'(1);
            end else begin
              mode_cnt <= '0;
              mstate <= icgc_pkg::ICGC_WAIT_REF;
            end
          end
        end
        icgc_pkg::ICGC_WAIT_REF: begin
          if (!in_off && (mode_req != 2'h2 || ext_reference_valid)) begin
            active_mode <= icgc_pkg::icgc_mode_t'(mode_req);
            mstate <= icgc_pkg::ICGC_IDLE;
          end
        end
        default: begin
          mstate <= icgc_pkg::ICGC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop_multiplier_code <= 3'h0;
      mul_applied <= 3'h0;
      mul_cnt <= '0;
    end else if (mul_take) begin
      loop_multiplier_code <= wr_mul;
      mul_cnt <= SW'(SETTLE_CYC);
    end else if (mul_busy) begin
      mul_cnt <= mul_cnt - SW'(1);
      if (mul_cnt == SW'(1)) begin
        mul_applied <= loop_multiplier_code;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_divider_code <= 3'h0;
      div_applied <= 3'h0;
      div_cnt <= '0;
    end else if (div_take) begin
      output_divider_code <= wr_div;
      div_cnt <= SW'(SETTLE_CYC);
    end else if (div_busy) begin
      div_cnt <= div_cnt - SW'(1);
      if (div_cnt == SW'(1)) begin
        div_applied <= output_divider_code;
      end
    end
  end

  // enable pulse every two to the code cycles
  wire [6:0] div_mask = 7'(8'h7F >> (3'h7 - div_applied));
  wire div_wrap = ((div_cnt_clk & div_mask) == div_mask);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_clk <= 7'h00;
      out_clk_en <= 1'b0;
    end else if (in_off) begin
      // output clock static in off
      out_clk_en <= 1'b0;
    end else begin
      div_cnt_clk <= div_wrap ? 7'h00 : div_cnt_clk + 7'h01;
      out_clk_en <= div_wrap;
    end
  end

  // pin inputs pass two flops first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_sync <= 2'h0;
      ref_prev <= 1'b0;
      lock_sync <= 2'h0;
      lock_prev <= 1'b0;
      loss_sync <= 2'h0;
    end else begin
      ref_sync <= {ref_sync[0], external_reference_clock};
      ref_prev <= ref_sync[1];
      lock_sync <= {lock_sync[0], loop_locked};
      lock_prev <= lock_sync[1];
      loss_sync <= {loss_sync[0], clock_loss_event};
    end
  end

  // qualify reference: edges close enough, enough in a row
  // slow or stopped references fall out after one gap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_cnt <= '0;
      edge_cnt <= '0;
      ext_reference_valid <= 1'b0;
    end else if (ref_edge) begin
      gap_cnt <= '0;
      if (edge_cnt < EW'(REF_EDGES)) begin
        edge_cnt <= edge_cnt + EW'(1);
      end else begin
        ext_reference_valid <= 1'b1;
      end
    end else if (gap_cnt >= GW'(REF_GAP_CYC)) begin
      edge_cnt <= '0;
      ext_reference_valid <= 1'b0;
    end else begin
      gap_cnt <= gap_cnt + GW'(1);
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_lost_flag <= 1'b0;
      clock_lost_flag <= 1'b0;
    end else begin
      lock_lost_flag <= lol_evt | (lock_lost_flag & ~clr_lol);
      clock_lost_flag <= loc_evt | (clock_lost_flag & ~clr_loc);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      requests <= '0;
    end else begin
      requests.lock_loss_irq <= lock_lost_flag & ~lock_loss_action;
      requests.lock_loss_reset <= lock_lost_flag & lock_loss_action;
      requests.clock_loss_irq <= clock_lost_flag & ~clock_loss_action;
      requests.clock_loss_reset <= clock_lost_flag & clock_loss_action;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_enable <= 1'b0;
      high_gain_select <= 1'b0;
      range_effective <= 1'b0;
      ext_reference_select <= 1'b0;
      loop_cfg <= '0;
    end else begin
      osc_enable <= next_osc;
      high_gain_select <= hgs;
      range_effective <= range_sel & ext_mode_now;
      ext_reference_select <= ers;
      loop_cfg.prescale <= (range_sel & ext_mode_now) ?
                           `ICGC_P_HIGH : `ICGC_P_LOW;
      loop_cfg.multiplier <= `ICGC_N_BASE + {1'b0, mul_applied, 1'b0};
      loop_cfg.divider_code <= div_applied;
    end
  end

endmodule

`default_nettype wire

// >>> core/icgc_params.svh
// constants for the clock generator control block: offsets, fields, resets
// assumes inclusion by the control module only
`ifndef ICGC_PARAMS_SVH
`define ICGC_PARAMS_SVH

// register indices on the plain register port
`define ICGC_ADDR_CTRL_ONE 2'h0
`define ICGC_ADDR_CTRL_TWO 2'h1
`define ICGC_ADDR_STATUS 2'h2

// first control register fields
`define ICGC_HGS_BIT 7
`define ICGC_RANGE_BIT 6
`define ICGC_ERS_BIT 5
`define ICGC_MODE_HI 4
`define ICGC_MODE_LO 3
`define ICGC_OSC_OFF_BIT 2
`define ICGC_CLOCK_LOSS_DETECT_OFF_BIT 1

// second control register fields
`define ICGC_LLA_BIT 7
`define ICGC_MUL_HI 6
`define ICGC_MUL_LO 4
`define ICGC_CLA_BIT 3
`define ICGC_DIV_HI 2
`define ICGC_DIV_LO 0

// status register fields
`define ICGC_ST_MODE_HI 7
`define ICGC_ST_MODE_LO 6
`define ICGC_ST_REFK_BIT 5
`define ICGC_ST_LOL_BIT 4
`define ICGC_ST_LOCK_BIT 3
`define ICGC_ST_LOC_BIT 2
`define ICGC_ST_ERV_BIT 1

// reset values
`define ICGC_CTRL_ONE_RST 8'h00
`define ICGC_CTRL_TWO_RST 8'h00

// loop prescale factor per range
`define ICGC_P_LOW 7'h40
`define ICGC_P_HIGH 7'h01

// loop factor base; the step of two is applied in the control module
`define ICGC_N_BASE 5'h04

// default cycle counts for settling and reference qualification
`define ICGC_SETTLE_CYC 8
`define ICGC_REF_GAP_CYC 64
`define ICGC_REF_EDGES 4

`endif

// >>> core/icgc_pkg.sv
// types shared by the clock generator control block
// assumes icgc_params.svh is on the include path
package icgc_pkg;

  typedef enum logic [1:0] {
    ICGC_SELF_CLOCKED,
    ICGC_LOOP_INTERNAL,
    ICGC_EXT_BYPASS,
    ICGC_LOOP_EXTERNAL
  } icgc_mode_t;

  typedef enum {
    ICGC_IDLE,
    ICGC_SETTLE,
    ICGC_WAIT_REF
  } icgc_mstate_t;

  typedef struct packed {
    logic lock_loss_irq;
    logic lock_loss_reset;
    logic clock_loss_irq;
    logic clock_loss_reset;
  } icgc_req_t;

  typedef struct packed {
    logic [6:0] prescale;
    logic [4:0] multiplier;
    logic [2:0] divider_code;
  } icgc_loop_t;

endpackage

// >>> test/icgc_ctrl_checker.sv
// port-level checker for the clock generator control block
// assumes one bus clock domain; bound into every icgc_ctrl
`timescale 1ns/1ps
`default_nettype none
module icgc_ctrl_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic stop_request,
  input wire logic range_effective,
  input wire icgc_pkg::icgc_mode_t active_mode,
  input wire icgc_pkg::icgc_loop_t loop_cfg,
  input wire logic out_clk_en,
  input wire icgc_pkg::icgc_req_t requests
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  chk_bit0_zero: assert property (
    $past(rd) && $past(addr) == 2'h0 |-> !rdata[0])
    else $error("control bit 0 read as one");
  chk_range_gate: assert property (
    range_effective |-> active_mode[1] || $past(active_mode[1]))
    else $error("range effective outside external modes");
  // slack of a few cycles: prescale may trail the mode by one register
  chk_ps_low: assert property (
    (!active_mode[1])[*3] |-> loop_cfg.prescale == 7'h40)
    else $error("prescale not 64 in internal modes");
  chk_ps_high: assert property (
    range_effective[*3] |-> loop_cfg.prescale == 7'h01)
    else $error("prescale not 1 in high range");
  chk_mul_legal: assert property (
    $past(resetn) |-> !loop_cfg.multiplier[0]
      && loop_cfg.multiplier >= 5'h04 && loop_cfg.multiplier <= 5'h12)
    else $error("loop factor outside 4 to 18 or odd");
  chk_div_one: assert property (
    (loop_cfg.divider_code == 3'h0 && !stop_request)[*3] |-> out_clk_en)
    else $error("divide by one missed a pulse");
  chk_div_two: assert property (
    (loop_cfg.divider_code == 3'h1 && !stop_request)[*4]
      |-> out_clk_en != $past(out_clk_en))
    else $error("divide by two not alternating");
  chk_off_hold: assert property (
    stop_request[*2] |-> $stable(active_mode) && !out_clk_en)
    else $error("mode moved or clock ran in off mode");
  chk_lock_req: assert property (
    !(requests.lock_loss_irq && requests.lock_loss_reset))
    else $error("lock loss raised both request kinds");
  chk_clk_req: assert property (
    !(requests.clock_loss_irq && requests.clock_loss_reset))
    else $error("clock loss raised both request kinds");
endmodule
bind icgc_ctrl icgc_ctrl_checker u_icgc_ctrl_checker (.clk(clk),
  .resetn(resetn), .addr(addr), .rd(rd), .rdata(rdata),
  .stop_request(stop_request), .range_effective(range_effective),
  .active_mode(active_mode), .loop_cfg(loop_cfg), .out_clk_en(out_clk_en),
  .requests(requests));
`default_nettype wire

// >>> test/icgc_ref_model.sv
// external reference source: crystal or square-wave clock
// assumes nothing of the bus clock; phase unrelated on purpose
`timescale 1ns/1ps
`default_nettype none
module icgc_ref_model #(
  parameter real HALF_NS = 33.3
) (
  input wire logic run,
  input wire logic slow,
  output logic ref_clk
);
  // stands low when stopped, so no stale edges qualify the reference
  initial begin
    ref_clk = 1'b0;
    forever begin
      #(slow ? HALF_NS * 10.0 : HALF_NS);
      ref_clk = run ? ~ref_clk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the clock generator control registers
// assumes icgc_ctrl, its bound checker and the reference model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SET = 2;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic ref_run = 1'b0, ref_slow = 1'b0, ref_clk;
  logic locked = 1'b0, loss = 1'b0, stop = 1'b0, osc_req = 1'b0;
  logic [7:0] rdata, d;
  logic [15:0] me;
  logic osc_en, hgs, rng, ers, oclk;
  icgc_pkg::icgc_mode_t mode;
  icgc_pkg::icgc_loop_t lcfg;
  icgc_pkg::icgc_req_t req;
  logic [15:0] expq[$];
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  icgc_ctrl #(.SETTLE_CYC(SET), .REF_GAP_CYC(8), .REF_EDGES(1)) u_icgc_ctrl (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .external_reference_clock(ref_clk),
    .loop_locked(locked), .clock_loss_event(loss), .stop_request(stop),
    .osc_enable_request(osc_req), .osc_enable(osc_en),
    .high_gain_select(hgs),
    .range_effective(rng), .ext_reference_select(ers), .active_mode(mode),
    .loop_cfg(lcfg), .out_clk_en(oclk), .requests(req));
  icgc_ref_model u_icgc_ref_model (.run(ref_run), .slow(ref_slow),
    .ref_clk(ref_clk));
  always #10 clk = ~clk;
  task automatic complete_run();
    $display("mismatches %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  // one bus cycle; reads leave their masked expectation in the queue
  task automatic op(input logic w, r, input logic [1:0] a,
                    input logic [7:0] dat, input logic [15:0] mx);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= dat;
    if (r) expq.push_back(mx);
    @(posedge clk);
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] dat);
    op(1'b1, 1'b0, a, dat, 16'h0000);
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] m, e);
    op(1'b0, 1'b1, a, 8'h00, {m, e});
  endtask
  task automatic idle(input int c);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (c) @(posedge clk);
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    idle(5);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [3:0] cur(input logic k);
    return k ? 4'(req) : 4'(mode);
  endfunction
  // bounded wait on the mode (k=0) or the request lines (k=1)
  task automatic wait_for(input logic k, input logic [3:0] e);
    n = 0;
    wr <= 1'b0;
    rd <= 1'b0;
    while (cur(k) !== e && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("wait", 8'(e), 8'(cur(k)));
    if (cur(k) !== e) complete_run();
  endtask
  always @(posedge clk) rd_q <= rd;
  // read data stand only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_q) begin
      me = (expq.size() > 0) ? expq.pop_front() : 16'hFF00;
      chk("rdata", me[7:0] & me[15:8], rdata & me[15:8]);
    end
  end
  initial begin
    void'($urandom(32'h9714C6BE));
    do_reset();
    chk("mode", 8'h00, 8'(mode));
    chk("ps", 8'h40, 8'(lcfg.prescale));
    chk("mul", 8'h04, 8'(lcfg.multiplier));
    rreg(2'h3, 8'hFF, 8'h00);
    wreg(2'h0, 8'hFF);
    wreg(2'h0, 8'h00);
    rreg(2'h0, 8'hFF, 8'hF8);
    idle(1);
    chk("gain", 8'h01, 8'(hgs));
    chk("rsel", 8'h01, 8'(ers));
    wait_for(1'b0, 4'h3);
    idle(3);
    chk("reff", 8'h01, 8'(rng));
    wreg(2'h0, 8'h10);
    ref_slow <= 1'b1;
    ref_run <= 1'b1;
    idle(200);
    chk("mode", 8'h03, 8'(mode));
    rreg(2'h2, 8'h02, 8'h00);
    ref_slow <= 1'b0;
    wait_for(1'b0, 4'h2);
    rreg(2'h2, 8'hC2, 8'h82);
    stop <= 1'b1;
    idle(6);
    chk("osc", 8'h01, 8'(osc_en));
    rreg(2'h0, 8'h18, 8'h10);
    stop <= 1'b0;
    ref_run <= 1'b0;
    idle(30);
    rreg(2'h2, 8'h02, 8'h00);
    idle(2);
    do_reset();
    wreg(2'h0, 8'h0C);
    wait_for(1'b0, 4'h1);
    wreg(2'h0, 8'hF4);
    rreg(2'h0, 8'hFF, 8'h0C);
    stop <= 1'b1;
    idle(SET + 6);
    chk("osc", 8'h00, 8'(osc_en));
    stop <= 1'b0;
    idle(2);
    for (int i = 0; i < 8; i++) begin
      d = {1'($urandom), 3'(i), 1'($urandom), 3'(i)};
      wreg(2'h1, d);
      rreg(2'h1, 8'hFF, d);
      idle(SET + 4);
      chk("mul", 8'(4 + 2 * i), 8'(lcfg.multiplier));
      chk("div", 8'(i), 8'(lcfg.divider_code));
      n = 0;
      repeat (128) begin
        @(negedge clk);
        n += int'(oclk);
      end
      chk("pulses", 8'(128 >> i), 8'(n));
      @(posedge clk);
    end
    wreg(2'h1, 8'h00);
    wreg(2'h1, 8'hFF);
    rreg(2'h1, 8'hFF, 8'h88);
    loss <= 1'b1;
    idle(3);
    loss <= 1'b0;
    wait_for(1'b1, 4'b0001);
    wreg(2'h1, 8'h00);
    wait_for(1'b1, 4'b0010);
    wreg(2'h2, 8'h04);
    wait_for(1'b1, 4'b0000);
    wreg(2'h0, 8'h0E);
    loss <= 1'b1;
    idle(8);
    chk("req", 8'h00, 8'(req));
    loss <= 1'b0;
    locked <= 1'b1;
    idle(8);
    locked <= 1'b0;
    wait_for(1'b1, 4'b1000);
    rreg(2'h2, 8'h10, 8'h10);
    wreg(2'h1, 8'h80);
    wait_for(1'b1, 4'b0100);
    wreg(2'h2, 8'h10);
    wait_for(1'b1, 4'b0000);
    idle(3);
    // off mode with keep bit clear: enable input decides in bypass
    do_reset();
    wreg(2'h0, 8'h30);
    stop <= 1'b1;
    idle(4);
    chk("osc", 8'h00, 8'(osc_en));
    osc_req <= 1'b1;
    idle(3);
    chk("osc", 8'h01, 8'(osc_en));
    stop <= 1'b0;
    osc_req <= 1'b0;
    idle(3);
    complete_run();
  end
endmodule
`default_nettype wire
